// [common/rtcai_regs.svh]
// Register offsets, field positions, reset values and timing counts of the RTC core
`ifndef RTCAI_REGS_SVH
`define RTCAI_REGS_SVH
`define RTCAI_CLK_HZ 100000000
`define RTCAI_XTAL_HZ 32768
`define RTCAI_HUND_STEP 100
`define RTCAI_PULSE_MS 210
`define RTCAI_PULSE_CYC (`RTCAI_PULSE_MS * (`RTCAI_CLK_HZ / 1000))
`define RTCAI_TIME_ADR 8'h00
`define RTCAI_CAL_ADR 8'h04
`define RTCAI_CTRL_ADR 8'h08
`define RTCAI_STS_ADR 8'h0c
`define RTCAI_MASK_ADR 8'h10
`define RTCAI_ALMA_ADR 8'h14
`define RTCAI_ALMB_ADR 8'h18
`define RTCAI_TMR_ADR 8'h1c
`define RTCAI_C_FSEL 0
`define RTCAI_C_SRC 1
`define RTCAI_C_ALME 3
`define RTCAI_C_IM 4
`define RTCAI_C_FRQ 5
`define RTCAI_C_FEN 7
`define RTCAI_C_LP 8
`define RTCAI_C_TEN 9
`define RTCAI_C_P1ALM 10
`define RTCAI_CTRL_W 11
`define RTCAI_S_ALM 0
`define RTCAI_S_TMR 1
`define RTCAI_S_BKP 2
`define RTCAI_AE 7
`define RTCAI_DATE_RST 8'h01
`define RTCAI_MON_RST 8'h01
`endif

// [common/rtcai_pkg.sv]
// Types of the RTC core
`include "rtcai_regs.svh"
package rtcai_pkg;
  typedef enum logic {RTCAI_NORMAL, RTCAI_BACKUP} rtcai_pwr_t;
  typedef struct packed {
    rtcai_pwr_t               pwr;
    logic [7:0]               hund;
    logic [7:0]               sec;
    logic [7:0]               min;
    logic [7:0]               hour;
    logic [7:0]               dow;
    logic [7:0]               date;
    logic [7:0]               mon;
    logic [7:0]               year;
    logic [`RTCAI_CTRL_W-1:0] ctrl;
    logic [1:0]               sts;
    logic [1:0]               msk;
    logic [31:0]              alma;
    logic [15:0]              almb;
    logic [7:0]               trl;
    logic [7:0]               tcnt;
    logic                     step;
    logic [24:0]              pulse;
    logic                     ack;
    logic                     err;
    logic [31:0]              dat;
    logic                     irq;
    logic                     p1;
    logic                     p2;
    logic                     scl;
    logic                     sda;
    logic                     sda_oe;
    logic                     low;
  } rtcai_core_t;
  typedef struct packed {
    logic        xq;
    logic [15:0] acc;
    logic [4:0]  div;
    logic        tick;
  } rtcai_tb_t;
endpackage : rtcai_pkg

// [common/rtcai_tb_if.sv]
// Time base signals between core and crystal divider
`timescale 1ns/10ps
interface rtcai_tb_if;
  logic       xtal_s;
  logic       hund_tick;
  logic [4:0] div;
  modport tb (input xtal_s, output hund_tick, output div);
  modport core (output xtal_s, input hund_tick, input div);
endinterface : rtcai_tb_if

// [rtl/rtcai_sync.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module rtcai_sync #(
  parameter int W = 7
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output wire logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] m;
    logic [W-1:0] q;
  } rtcai_sync_t;
  rtcai_sync_t s;
  rtcai_sync_t n;

  always_comb begin
    n.m = d_i;
    n.q = s.m;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign q_o = s.q;
endmodule : rtcai_sync

// [rtl/rtcai_tbase.sv]
// Crystal edge divider and hundredths tick generator
`timescale 1ns/10ps
`include "rtcai_regs.svh"
module rtcai_tbase (
  input wire logic clk_i,
  input wire logic rst_i,
  rtcai_tb_if.tb   tb
);
  rtcai_pkg::rtcai_tb_t s;
  rtcai_pkg::rtcai_tb_t n;
  logic [16:0]          sum;

  // Exact 100 ticks per 32768 crystal edges
  always_comb begin
    n = s;
    sum = {1'b0, s.acc} + 17'(`RTCAI_HUND_STEP);
    n.xq = tb.xtal_s;
    n.tick = 1'b0;
    if (tb.xtal_s && !s.xq) begin
      n.div = s.div + 5'd1;
      n.tick = sum >= 17'(`RTCAI_XTAL_HZ);
      n.acc = n.tick ? 16'(sum - 17'(`RTCAI_XTAL_HZ)) : sum[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      s <= '0;
    else
      s <= n;
  end

  assign tb.hund_tick = s.tick;
  assign tb.div = s.div;
endmodule : rtcai_tbase

// [rtl/rtcai_top.sv]
// RTC core with calendar, alarm, timer, interrupt pins and supply switchover
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`include "rtcai_regs.svh"
// Function
// - Count hundredths to hours from crystal ticks
// - Calendar counters with leap years to 2099
// - Alarm matches any chosen field combination
// - Alarm match sets flag, drives pins
// - Repeat mode alarms on every recurring match
// - Timer expiry sets flag, second pin only
// - First pin function chosen by control bit
// - Frequency mode drives selected crystal clock
// - Second pin source chosen by control bits
// - Serial pins disabled in backup mode
// - Serial data only pulled low
// - Backup needs below battery and trip level
// - Return when above battery or trip
// - Repeat match pulls pin 210 ms
// - Low power mode ignores trip level
module rtcai_top #(
  parameter int unsigned PULSE_CYC = `RTCAI_PULSE_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output wire logic [31:0] wb_dat_o,
  output wire logic        wb_ack_o,
  output wire logic        wb_err_o,
  output wire logic        irq_o,
  input  wire logic        xtal_i,
  input  wire logic        vdd_lt_bat_i,
  input  wire logic        vdd_lt_trip_i,
  input  wire logic        vdd_gt_bat_i,
  input  wire logic        vdd_gt_trip_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic        sda_pull_i,
  output wire logic        ser_scl_o,
  output wire logic        ser_sda_o,
  output wire logic        sda_o,
  output wire logic        sda_oe_o,
  output wire logic        first_irq_or_freq_pin_o,
  output wire logic        first_irq_or_freq_pin_oe_o,
  output wire logic        second_irq_pin_o,
  output wire logic        second_irq_pin_oe_o,
  output wire logic        backup_o
);
  localparam rtcai_pkg::rtcai_core_t S_RST = '{
    pwr:     rtcai_pkg::RTCAI_NORMAL,
    date:    `RTCAI_DATE_RST,
    mon:     `RTCAI_MON_RST,
    default: '0
  };

  rtcai_pkg::rtcai_core_t s;
  rtcai_pkg::rtcai_core_t n;
  rtcai_tb_if             u_tbif ();
  logic [6:0]             pin_s;
  logic                   lt_bat;
  logic                   lt_trip;
  logic                   gt_bat;
  logic                   gt_trip;
  logic                   tk;
  logic                   c0;
  logic                   c1;
  logic                   c2;
  logic                   c3;
  logic                   c4;
  logic                   c5;
  logic                   alm_on;
  logic                   match;
  logic                   texp;
  logic                   alm_int;
  logic                   fclk;
  logic                   req;
  logic                   wr;
  logic [1:0]             clr;
  logic [31:0]            rd;
  logic [31:0]            w;
  logic [5:0]             hit;
  logic [5:0]             fen;
  logic [7:0]             cur_f [6];
  logic [7:0]             alm_f [6];

  function automatic logic [7:0] step(input logic [7:0] v, input logic [7:0] lo,
                                      input logic en, input logic wrap);
    step = !en ? v : (wrap ? lo : v + 8'h01);
  endfunction : step

  function automatic logic [7:0] dim(input logic [7:0] m, input logic [7:0] y);
    case (m)
      8'h02: dim = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
      8'h04, 8'h06, 8'h09, 8'h0b: dim = 8'h1e;
      default: dim = 8'h1f;
    endcase
  endfunction : dim

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = b[i] ? d[8*i +: 8] : o[8*i +: 8];
    end
  endfunction : merge

  rtcai_sync #(
    .W (7)
  ) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({sda_i, scl_i, vdd_gt_trip_i, vdd_gt_bat_i, vdd_lt_trip_i, vdd_lt_bat_i, xtal_i}),
    .q_o   (pin_s)
  );

  rtcai_tbase u_tbase (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .tb    (u_tbif.tb)
  );

  assign u_tbif.xtal_s = pin_s[0];
  assign lt_bat = pin_s[1];
  assign lt_trip = pin_s[2];
  assign gt_bat = pin_s[3];
  assign gt_trip = pin_s[4];

  // Alarm field compare, bit 7 of each byte enables the field
  assign cur_f = '{s.sec, s.min, s.hour, s.dow, s.date, s.mon};
  assign alm_f = '{s.alma[7:0], s.alma[15:8], s.alma[23:16], s.alma[31:24], s.almb[7:0], s.almb[15:8]};
  for (genvar i = 0; i < 6; i++) begin : g_fld
    assign fen[i] = alm_f[i][`RTCAI_AE];
    assign hit[i] = !fen[i] || (cur_f[i][6:0] == alm_f[i][6:0]);
  end

  always_comb begin
    n = s;
    // Carry chain of the time and calendar counters
    tk = u_tbif.hund_tick;
    c0 = tk && s.hund == 8'h63;
    c1 = c0 && s.sec == 8'h3b;
    c2 = c1 && s.min == 8'h3b;
    c3 = c2 && s.hour == 8'h17;
    c4 = c3 && s.date >= dim(s.mon, s.year);
    c5 = c4 && s.mon >= 8'h0c;
    n.hund = step(s.hund, 8'h00, tk, c0);
    n.sec = step(s.sec, 8'h00, c0, c1);
    n.min = step(s.min, 8'h00, c1, c2);
    n.hour = step(s.hour, 8'h00, c2, c3);
    n.dow = step(s.dow, 8'h00, c3, s.dow >= 8'h06);
    n.date = step(s.date, 8'h01, c3, c4);
    n.mon = step(s.mon, 8'h01, c4, c5);
    n.year = step(s.year, 8'h00, c5, s.year >= 8'h63);
    n.step = c0;
    // Alarm is off while the first pin carries the frequency output
    alm_on = s.ctrl[`RTCAI_C_ALME] && !(s.ctrl[`RTCAI_C_FEN] && s.ctrl[`RTCAI_C_FSEL]);
    match = s.step && (|fen) && (&hit) && alm_on;
    // Seconds timer, reloads on expiry
    texp = 1'b0;
    if (c0 && s.ctrl[`RTCAI_C_TEN]) begin
      texp = s.tcnt <= 8'h01;
      n.tcnt = texp ? s.trl : s.tcnt - 8'h01;
    end
    if (match && s.ctrl[`RTCAI_C_IM])
      n.pulse = 25'(PULSE_CYC);
    else if (s.pulse != 25'h0)
      n.pulse = s.pulse - 25'h1;
    // Supply switchover
    unique case (s.pwr)
      rtcai_pkg::RTCAI_NORMAL: begin
        if (lt_bat && (lt_trip || s.ctrl[`RTCAI_C_LP]))
          n.pwr = rtcai_pkg::RTCAI_BACKUP;
      end
      rtcai_pkg::RTCAI_BACKUP: begin
        if (gt_bat || (gt_trip && !s.ctrl[`RTCAI_C_LP]))
          n.pwr = rtcai_pkg::RTCAI_NORMAL;
      end
    endcase
    // Bus slave, refused while on backup supply
    req = wb_cyc_i && wb_stb_i && !s.ack && !s.err;
    n.ack = req && s.pwr == rtcai_pkg::RTCAI_NORMAL;
    n.err = req && s.pwr == rtcai_pkg::RTCAI_BACKUP;
    wr = n.ack && wb_we_i;
    case (wb_adr_i)
      `RTCAI_TIME_ADR: rd = {s.hour, s.min, s.sec, s.hund};
      `RTCAI_CAL_ADR: rd = {s.dow, s.year, s.mon, s.date};
      `RTCAI_CTRL_ADR: rd = {21'h0, s.ctrl};
      `RTCAI_STS_ADR: rd = {29'h0, s.pwr == rtcai_pkg::RTCAI_BACKUP, s.sts};
      `RTCAI_MASK_ADR: rd = {30'h0, s.msk};
      `RTCAI_ALMA_ADR: rd = s.alma;
      `RTCAI_ALMB_ADR: rd = {16'h0, s.almb};
      `RTCAI_TMR_ADR: rd = {24'h0, s.trl};
      default: rd = 32'h0;
    endcase
    n.dat = n.ack ? rd : 32'h0;
    w = merge(rd, wb_dat_i, wb_sel_i);
    clr = 2'h0;
    if (wr) begin
      case (wb_adr_i)
        `RTCAI_TIME_ADR: {n.hour, n.min, n.sec, n.hund} = w;
        `RTCAI_CAL_ADR: {n.dow, n.year, n.mon, n.date} = w;
        `RTCAI_CTRL_ADR: n.ctrl = w[`RTCAI_CTRL_W-1:0];
        `RTCAI_STS_ADR: clr = wb_sel_i[0] ? wb_dat_i[1:0] : 2'h0;
        `RTCAI_MASK_ADR: n.msk = w[1:0];
        `RTCAI_ALMA_ADR: n.alma = w;
        `RTCAI_ALMB_ADR: n.almb = w[15:0];
        `RTCAI_TMR_ADR: begin
          n.trl = w[7:0];
          n.tcnt = w[7:0];
        end
        default: ;
      endcase
    end
    // Sticky flags, a new event beats a clear
    n.sts[`RTCAI_S_ALM] = (s.sts[`RTCAI_S_ALM] && !clr[`RTCAI_S_ALM]) || match;
    n.sts[`RTCAI_S_TMR] = (s.sts[`RTCAI_S_TMR] && !clr[`RTCAI_S_TMR]) || texp;
    n.irq = |(n.sts & n.msk);
    // Pin drivers, enable high pulls the line low
    alm_int = s.ctrl[`RTCAI_C_IM] ? s.pulse != 25'h0 : s.sts[`RTCAI_S_ALM];
    unique case (s.ctrl[`RTCAI_C_FRQ +: 2])
      2'h0: fclk = u_tbif.xtal_s;
      2'h1: fclk = u_tbif.div[1];
      2'h2: fclk = u_tbif.div[2];
      2'h3: fclk = u_tbif.div[4];
    endcase
    if (s.ctrl[`RTCAI_C_FSEL])
      n.p1 = s.ctrl[`RTCAI_C_FEN] && !fclk;
    else
      n.p1 = s.ctrl[`RTCAI_C_P1ALM] && alm_int;
    n.p2 = (s.ctrl[`RTCAI_C_SRC] && alm_int) || (s.ctrl[`RTCAI_C_SRC+1] && s.sts[`RTCAI_S_TMR]);
    // Serial pins gated off on backup supply
    n.scl = s.pwr == rtcai_pkg::RTCAI_BACKUP || pin_s[5];
    n.sda = s.pwr == rtcai_pkg::RTCAI_BACKUP || pin_s[6];
    n.sda_oe = s.pwr == rtcai_pkg::RTCAI_NORMAL && sda_pull_i;
    n.low = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      s <= S_RST;
    else
      s <= n;
  end

  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign wb_err_o = s.err;
  assign irq_o = s.irq;
  assign ser_scl_o = s.scl;
  assign ser_sda_o = s.sda;
  assign sda_o = s.low;
  assign sda_oe_o = s.sda_oe;
  assign first_irq_or_freq_pin_o = s.low;
  assign first_irq_or_freq_pin_oe_o = s.p1;
  assign second_irq_pin_o = s.low;
  assign second_irq_pin_oe_o = s.p2;
  assign backup_o = s.pwr == rtcai_pkg::RTCAI_BACKUP;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence sq_bkp_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && s.pwr == rtcai_pkg::RTCAI_BACKUP;
  endsequence
  sequence sq_sec_wrap;
    tk && s.hund == 8'h63 && s.sec != 8'h3b && !wb_cyc_i;
  endsequence
  sequence sq_feb_end;
    c3 && s.mon == 8'h02 && s.date == 8'h1c && s.year[1:0] == 2'h0 && !wb_cyc_i;
  endsequence
  sequence sq_norm_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o && s.pwr == rtcai_pkg::RTCAI_NORMAL;
  endsequence

  a_bkp_refuse:
    assert property (sq_bkp_req |=> wb_err_o && !wb_ack_o ##1 !wb_err_o)
    else $error("bus served on backup supply");
  a_sda_pull_only:
    assert property (sda_oe_o |-> !sda_o && $past(s.pwr) == rtcai_pkg::RTCAI_NORMAL)
    else $error("serial data driven high or in backup");
  a_hund_carry:
    assert property (sq_sec_wrap |=> s.hund == 8'h00 && s.sec == $past(s.sec) + 8'h01)
    else $error("hundredths carry lost");
  a_leap_day:
    assert property (sq_feb_end |=> s.date == 8'h1d && s.mon == 8'h02)
    else $error("leap day skipped");
  a_alarm_flag:
    assert property (match |=> s.sts[`RTCAI_S_ALM] ##1 s.pulse != 25'h0 || !s.ctrl[`RTCAI_C_IM])
    else $error("alarm match not recorded");
  a_pulse_load:
    assert property (match && s.ctrl[`RTCAI_C_IM] |=> s.pulse == 25'(PULSE_CYC))
    else $error("repeat pulse not started");
  a_pin2_src:
    assert property (s.sts[`RTCAI_S_TMR] && s.ctrl[`RTCAI_C_SRC+1] |=> second_irq_pin_oe_o)
    else $error("timer not on second pin");
  a_timer_flag:
    assert property (texp |=> s.sts[`RTCAI_S_TMR])
    else $error("timer expiry not recorded");
  a_freq_pin:
    assert property (s.ctrl[`RTCAI_C_FSEL] && s.ctrl[`RTCAI_C_FEN] |=> first_irq_or_freq_pin_oe_o == !$past(fclk))
    else $error("frequency output wrong");
  a_bkp_enter:
    assert property (s.pwr == rtcai_pkg::RTCAI_NORMAL && lt_bat && (lt_trip || s.ctrl[`RTCAI_C_LP])
                     |=> backup_o)
    else $error("backup not entered");
  a_bkp_exit:
    assert property (s.pwr == rtcai_pkg::RTCAI_BACKUP && gt_bat |=> !backup_o)
    else $error("backup not left");
  a_bus_answer:
    assert property (sq_norm_req |=> wb_ack_o && !wb_err_o ##1 !wb_ack_o)
    else $error("bus not answered in one cycle");
  a_dat_idle:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_refused_write:
    assert property (sq_bkp_req |=> s.ctrl == $past(s.ctrl))
    else $error("write taken on backup supply");
  a_serial_gate:
    assert property (backup_o |=> ser_scl_o && ser_sda_o && !sda_oe_o)
    else $error("serial pins live in backup");
  a_irq_level:
    assert property (irq_o == |(s.sts & s.msk))
    else $error("interrupt level wrong");
  a_single_pin:
    assert property (!s.ctrl[`RTCAI_C_IM] && s.ctrl[`RTCAI_C_P1ALM] && !s.ctrl[`RTCAI_C_FSEL]
                     && s.sts[`RTCAI_S_ALM] |=> first_irq_or_freq_pin_oe_o)
    else $error("single alarm not on first pin");
  a_p2_alarm:
    assert property (s.ctrl[`RTCAI_C_SRC] && !s.ctrl[`RTCAI_C_IM] && s.sts[`RTCAI_S_ALM]
                     |=> second_irq_pin_oe_o)
    else $error("alarm not on second pin");
  a_timer_reload:
    assert property (texp && !wb_cyc_i |=> s.tcnt == $past(s.trl))
    else $error("timer not reloaded");
  a_pulse_count:
    assert property (s.pulse != 25'h0 && !match |=> s.pulse == $past(s.pulse) - 25'h1)
    else $error("pulse length counter skipped");
  a_dow_wrap:
    assert property (c3 && s.dow == 8'h06 && !wb_cyc_i |=> s.dow == 8'h00)
    else $error("weekday did not wrap");
endmodule : rtcai_top

// [test/rtcai_host_model.sv]
// Serial host side: open-drain bus wires with pull-ups
`timescale 1ns/10ps
module rtcai_host_model (
  input  wire logic host_pull_i,
  input  wire logic dev_oe_i,
  input  wire logic dev_o,
  output wire logic scl_o,
  output wire logic sda_o
);
  // No frames are sent, so the clock rests at its pull-up level
  assign scl_o = 1'b1;
  // Wired data line: any pull wins, else the pull-up
  assign sda_o = ((dev_oe_i === 1'b1 && dev_o === 1'b0) || host_pull_i) ? 1'b0 : 1'b1;
endmodule : rtcai_host_model

// [test/rtc_alarm_irq_power_switch_test.sv]
// Self-checking bench of the RTC core
`timescale 1ns/10ps
`include "rtcai_regs.svh"
module rtc_alarm_irq_power_switch_test;
  logic        clk_i, rst_i, cyc, stb, we, xtal, lt_bat, lt_trip, gt_bat, gt_trip, sda_pull;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, dat_o;
  logic        ack, err, irq, scl_w, sda_w, ser_scl, ser_sda, sda_o, sda_oe, p1_o, p1_oe, p2_o, p2_oe;
  logic        backup, got_err;
  int          n_mismatch, tests_run, cycles;

  rtcai_top #(.PULSE_CYC(50)) u_rtcai_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .wb_err_o(err), .irq_o(irq), .xtal_i(xtal), .vdd_lt_bat_i(lt_bat), .vdd_lt_trip_i(lt_trip),
    .vdd_gt_bat_i(gt_bat), .vdd_gt_trip_i(gt_trip), .scl_i(scl_w), .sda_i(sda_w), .sda_pull_i(sda_pull),
    .ser_scl_o(ser_scl), .ser_sda_o(ser_sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .first_irq_or_freq_pin_o(p1_o), .first_irq_or_freq_pin_oe_o(p1_oe), .second_irq_pin_o(p2_o),
    .second_irq_pin_oe_o(p2_oe), .backup_o(backup));
  rtcai_host_model u_rtcai_host_model (.host_pull_i(1'b0), .dev_oe_i(sda_oe), .dev_o(sda_o), .scl_o(scl_w),
    .sda_o(sda_w));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Crystal stand-in with a 4-cycle period, and the hang limit
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles[0]) xtal <= ~xtal;
    if (cycles == 60000) begin
      n_mismatch = n_mismatch + 1;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : wt

  // Classic single cycle; request held until ack or err is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1);
    rdat = dat_o;
    got_err = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("bus latency", n, 32'd2);
  endtask : wb

  task automatic t_reset();
    wb(1'b0, `RTCAI_CTRL_ADR, 32'h0);
    chk("ctrl reset", rdat, 32'h0);
    wb(1'b0, `RTCAI_CAL_ADR, 32'h0);
    chk("calendar reset", rdat, 32'h0000_0101);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped read", rdat, 32'h0);
    chk("pins idle", {p1_oe, p2_oe, irq, p1_o, p2_o}, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_alarm();
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0000_040a);
    wb(1'b1, `RTCAI_MASK_ADR, 32'h1);
    wb(1'b1, `RTCAI_ALMA_ADR, 32'h0000_0086);
    wb(1'b1, `RTCAI_TIME_ADR, 32'h0000_0563);
    do begin
      wb(1'b0, `RTCAI_STS_ADR, 32'h0);
    end while (rdat[0] !== 1'b1);
    wb(1'b0, `RTCAI_TIME_ADR, 32'h0);
    chk("seconds after carry", rdat[15:8], 32'h6);
    wt(2);
    chk("irq raised", irq, 32'h1);
    chk("first pin", {p1_oe, p1_o}, 32'h2);
    chk("second pin", {p2_oe, p2_o}, 32'h2);
    wb(1'b1, `RTCAI_MASK_ADR, 32'h0);
    wt(2);
    chk("irq masked", irq, 32'h0);
    wb(1'b1, `RTCAI_STS_ADR, 32'h1);
    wb(1'b1, `RTCAI_MASK_ADR, 32'h1);
    wt(2);
    chk("pins released", {p1_oe, p2_oe, irq}, 32'h0);
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_repeat();
    int hi;
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0000_0418);
    wb(1'b1, `RTCAI_TIME_ADR, 32'h0000_0563);
    while (p1_oe !== 1'b1) begin
      @(posedge clk_i);
    end
    hi = 0;
    while (p1_oe === 1'b1 && hi < 100) begin
      chk("second pin unselected", p2_oe, 32'h0);
      @(posedge clk_i);
      hi++;
    end
    chk("pulse length", hi, 32'd50);
    wb(1'b0, `RTCAI_STS_ADR, 32'h0);
    chk("repeat flag", rdat[0], 32'h1);
    wb(1'b1, `RTCAI_STS_ADR, 32'h1);
    $display("test repeat done");
  endtask : t_repeat

  task automatic t_timer();
    wb(1'b1, `RTCAI_TMR_ADR, 32'h1);
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0000_0604);
    wb(1'b1, `RTCAI_MASK_ADR, 32'h2);
    wb(1'b1, `RTCAI_TIME_ADR, 32'h0000_0063);
    do begin
      wb(1'b0, `RTCAI_STS_ADR, 32'h0);
    end while (rdat[1] !== 1'b1);
    chk("alarm flag quiet", rdat[0], 32'h0);
    wt(2);
    chk("timer pins", {p2_oe, p1_oe, irq}, 32'h5);
    wb(1'b1, `RTCAI_STS_ADR, 32'h2);
    wt(2);
    chk("timer pins released", {p2_oe, irq}, 32'h0);
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0);
    $display("test timer done");
  endtask : t_timer

  task automatic count_tog(output int tog);
    logic last;
    tog = 0;
    last = p1_oe;
    repeat (64) begin
      @(posedge clk_i);
      if (p1_oe !== last) tog++;
      last = p1_oe;
    end
  endtask : count_tog

  task automatic t_freq();
    int tog;
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0000_0081);
    count_tog(tog);
    chk("fast clock out", tog >= 24, 32'h1);
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0000_00e1);
    count_tog(tog);
    chk("slow clock out", tog <= 2, 32'h1);
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0);
    $display("test freq done");
  endtask : t_freq

  task automatic t_power();
    @(posedge clk_i);
    sda_pull <= 1'b1;
    lt_bat <= 1'b1;
    wt(6);
    chk("data pulled", {sda_oe, sda_o, sda_w, ser_sda}, 32'h8);
    chk("above trip stays", backup, 32'h0);
    @(posedge clk_i);
    lt_trip <= 1'b1;
    wt(6);
    chk("backup entered", backup, 32'h1);
    chk("serial off", {sda_oe, ser_scl, ser_sda}, 32'h3);
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0000_0008);
    chk("bus refused", got_err, 32'h1);
    @(posedge clk_i);
    lt_bat <= 1'b0;
    lt_trip <= 1'b0;
    gt_trip <= 1'b1;
    wt(6);
    chk("return over trip", backup, 32'h0);
    wb(1'b0, `RTCAI_CTRL_ADR, 32'h0);
    chk("refused write lost", rdat, 32'h0);
    gt_trip <= 1'b0;
    wb(1'b1, `RTCAI_CTRL_ADR, 32'h0000_0100);
    lt_bat <= 1'b1;
    wt(6);
    chk("low power switch", backup, 32'h1);
    @(posedge clk_i);
    lt_bat <= 1'b0;
    gt_trip <= 1'b1;
    wt(6);
    chk("trip ignored", backup, 32'h1);
    @(posedge clk_i);
    gt_bat <= 1'b1;
    wt(6);
    chk("return over battery", backup, 32'h0);
    $display("test power done");
  endtask : t_power

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    cycles = 0;
    xtal = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we, adr, wdat, lt_bat, lt_trip, gt_bat, gt_trip, sda_pull} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_alarm();
    t_repeat();
    t_timer();
    t_freq();
    t_power();
    print_verdict();
  end
endmodule : rtc_alarm_irq_power_switch_test
